/* File: common/usb_ep_pkg.sv */
`default_nettype none
package usb_ep_pkg;
    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int NUM_EP = 4;
    localparam int EP_W = 2;
    localparam int FIFO_DEPTH = 64;
    localparam int LVL_W = 7;
    localparam logic [LVL_W-1:0] EP0_MAX_PKT = 7'h08;
    localparam logic [LVL_W-1:0] EPN_MAX_PKT = 7'h40;
    localparam logic [NUM_EP-1:0] PP_MASK_DEF = 4'b0110;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CSR_BASE = 8'h00;
    localparam logic [ADDR_W-1:0] FIFO_BASE = 8'h04;
    localparam logic [ADDR_W-1:0] EP_STRIDE = 8'h08;
    localparam logic [ADDR_W-1:0] INT_EN_ADDR = 8'h40;
    localparam logic [ADDR_W-1:0] INT_PEND_ADDR = 8'h44;
    localparam logic [NUM_EP-1:0] INT_EN_RST = 4'h0;
    localparam int CSR_TX_COMPLETE_FLAG_BIT = 0;
    localparam int CSR_RXBK0_BIT = 1;
    localparam int CSR_SETUP_BIT = 2;
    localparam int CSR_STALLSENT_BIT = 3;
    localparam int CSR_TXRDY_BIT = 4;
    localparam int CSR_FSTALL_BIT = 5;
    localparam int CSR_PP_BIT = 6;
    localparam int CSR_CNT_LSB = 16;
    localparam int CSR_CNT_W = 11;
    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        TOK_SETUP = 2'b00,
        TOK_OUT = 2'b01,
        TOK_IN = 2'b10
    } tok_kind_t;
    typedef enum logic [1:0] {
        HS_ACK = 2'b00,
        HS_NAK = 2'b01,
        HS_STALL = 2'b10
    } hs_code_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RX = 2'b01,
        ST_TX = 2'b11,
        ST_TX_WAIT = 2'b10
    } dev_state_t;
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_SEND = 3'b001,
        H_WAIT = 3'b011
    } host_state_t;
endpackage : usb_ep_pkg
`default_nettype wire

/* File: common/usb_link_if.sv */
`default_nettype none
interface usb_link_if;
    import usb_ep_pkg::*;
    logic tok_valid;
    tok_kind_t tok_kind;
    logic [EP_W-1:0] tok_ep;
    logic hd_valid;
    logic [7:0] hd_data;
    logic hd_eop;
    logic hs_valid;
    hs_code_t hs_code;
    logic dh_valid;
    logic [7:0] dh_data;
    logic dh_eop;
    logic hack;
    logic hdrop;
    modport dev (
        input tok_valid, tok_kind, tok_ep, hd_valid, hd_data, hd_eop,
        input hack, hdrop,
        output hs_valid, hs_code, dh_valid, dh_data, dh_eop
    );
    modport host (
        output tok_valid, tok_kind, tok_ep, hd_valid, hd_data, hd_eop,
        output hack, hdrop,
        input hs_valid, hs_code, dh_valid, dh_data, dh_eop
    );
endinterface : usb_link_if
`default_nettype wire

/* File: design/ep_fifo_bank.sv */
`default_nettype none
module ep_fifo_bank #(
    parameter int DEPTH = 64,
    parameter int LW = 7
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clr_i,
    input wire logic rewind_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic [LW-1:0] level_o
);
    logic [7:0] mem [DEPTH];
    logic [LW-1:0] wptr_q;
    logic [LW-1:0] rptr_q;
    logic full;
    logic empty;

    assign full = (wptr_q == LW'(DEPTH));
    assign empty = (rptr_q == wptr_q);
    assign level_o = wptr_q - rptr_q;
    assign rdata_o = mem[rptr_q[LW-2:0]];

    // ************************************************************
    // Pointers
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || clr_i) begin
            wptr_q <= '0;
            rptr_q <= '0;
        end else begin
            if (wr_i && !full) begin
                wptr_q <= wptr_q + LW'(1);
            end
            if (rewind_i) begin
                rptr_q <= '0;
            end else if (rd_i && !empty) begin
                rptr_q <= rptr_q + LW'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (wr_i && !full && !clr_i) begin
            mem[wptr_q[LW-2:0]] <= wdata_i;
        end
    end
endmodule : ep_fifo_bank
`default_nettype wire

/* File: design/usb_endpoint_transaction_handler.sv */
`default_nettype none
module usb_endpoint_transaction_handler #(
    parameter logic [usb_ep_pkg::NUM_EP-1:0] PP_MASK =
        usb_ep_pkg::PP_MASK_DEF,
    parameter int DEPTH = usb_ep_pkg::FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    usb_link_if.dev link,
    input wire logic [usb_ep_pkg::ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [31:0] rdata_o,
    output logic [usb_ep_pkg::NUM_EP-1:0] ep_int_o
);
    import usb_ep_pkg::*;

    localparam int NB = 2 * NUM_EP;

    dev_state_t state_q;
    logic [EP_W-1:0] ep_q;
    tok_kind_t kind_q;
    logic store_q;
    hs_code_t pend_q;
    logic hs_valid_q;
    hs_code_t hs_code_q;
    logic dh_valid_q;
    logic [7:0] dh_data_q;
    logic dh_eop_q;
    logic [NUM_EP-1:0] setup_q, rxf_q, txc_q, stall_sent_q, fstall_q;
    logic [NUM_EP-1:0] fw_bank_q, usb_bank_q, int_en_q, pend;
    logic [NUM_EP-1:0][1:0] txrdy_q;
    logic [NUM_EP-1:0] csr_wr, fifo_wr, fifo_rd;
    logic [NUM_EP-1:0] ev_setup, ev_rx, ev_ack, ev_stall;
    logic [NB-1:0] bk_clr, bk_rew, bk_wr, bk_rd;
    logic [NB-1:0][7:0] bk_rdata;
    logic [NB-1:0][LVL_W-1:0] bk_level;
    logic [NB-1:0][7:0] bk_wdata;
    logic [31:0] rd_mux;
    logic [31:0] rdata_q;
    logic [EP_W:0] usb_b;
    logic [EP_W:0] tok_b0;
    logic [LVL_W-1:0] ep_max;
    logic rx_end;

    assign link.hs_valid = hs_valid_q;
    assign link.hs_code = hs_code_q;
    assign link.dh_valid = dh_valid_q;
    assign link.dh_data = dh_data_q;
    assign link.dh_eop = dh_eop_q;
    assign rdata_o = rdata_q;
    assign usb_b = {ep_q, usb_bank_q[ep_q]};
    assign tok_b0 = {link.tok_ep, 1'b0};
    assign ep_max = (ep_q == '0) ? EP0_MAX_PKT : EPN_MAX_PKT;
    assign rx_end = (state_q == ST_RX) && link.hd_eop && store_q;

    // ************************************************************
    // FIFO banks
    // ************************************************************
    for (genvar b = 0; b < NB; b++) begin : g_bank
        ep_fifo_bank #(.DEPTH(DEPTH), .LW(LVL_W)) u_bank (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .clr_i(bk_clr[b]),
            .rewind_i(bk_rew[b]),
            .wr_i(bk_wr[b]),
            .wdata_i(bk_wdata[b]),
            .rd_i(bk_rd[b]),
            .rdata_o(bk_rdata[b]),
            .level_o(bk_level[b])
        );
    end

    // ************************************************************
    // Register decode and events
    // ************************************************************
    always_comb begin
        for (int e = 0; e < NUM_EP; e++) begin
            csr_wr[e] = we_i && (addr_i == CSR_BASE + 8'(e) * EP_STRIDE);
            fifo_wr[e] = we_i && (addr_i == FIFO_BASE + 8'(e) * EP_STRIDE);
            fifo_rd[e] = re_i && (addr_i == FIFO_BASE + 8'(e) * EP_STRIDE);
            ev_setup[e] = rx_end && (kind_q == TOK_SETUP)
                && (ep_q == EP_W'(e));
            ev_rx[e] = rx_end && (kind_q == TOK_OUT) && (ep_q == EP_W'(e));
            ev_ack[e] = (state_q == ST_TX_WAIT) && link.hack
                && (ep_q == EP_W'(e));
            ev_stall[e] = (state_q == ST_IDLE) && link.tok_valid
                && (link.tok_kind != TOK_SETUP) && fstall_q[e]
                && (link.tok_ep == EP_W'(e));
        end
    end

    always_comb begin
        bk_clr = '0;
        bk_rew = '0;
        bk_wr = '0;
        bk_rd = '0;
        bk_wdata = {NB{wdata_i[7:0]}};
        if (state_q == ST_IDLE && link.tok_valid) begin
            if (link.tok_kind == TOK_SETUP) begin
                bk_clr[tok_b0] = 1'b1;
            end else if (link.tok_kind == TOK_OUT
                && !fstall_q[link.tok_ep] && !rxf_q[link.tok_ep]
                && !setup_q[link.tok_ep]) begin
                bk_clr[tok_b0] = 1'b1;
            end
        end
        if (state_q == ST_RX && store_q && link.hd_valid
            && bk_level[{ep_q, 1'b0}] < ep_max) begin
            bk_wr[{ep_q, 1'b0}] = 1'b1;
            bk_wdata[{ep_q, 1'b0}] = link.hd_data;
        end
        if (state_q == ST_TX && bk_level[usb_b] != '0) begin
            bk_rd[usb_b] = 1'b1;
        end
        if (state_q == ST_TX_WAIT) begin
            bk_clr[usb_b] = link.hack;
            bk_rew[usb_b] = link.hdrop;
        end
        for (int e = 0; e < NUM_EP; e++) begin
            if (fifo_wr[e]) begin
                bk_wr[{EP_W'(e), fw_bank_q[e]}] = 1'b1;
            end
            if (fifo_rd[e]) begin
                bk_rd[{EP_W'(e), 1'b0}] = 1'b1;
            end
            if (csr_wr[e] && (wdata_i[CSR_RXBK0_BIT]
                || wdata_i[CSR_SETUP_BIT])) begin
                bk_clr[{EP_W'(e), 1'b0}] = 1'b1;
            end
        end
    end

    // ************************************************************
    // Transaction sequencer
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            ep_q <= '0;
            kind_q <= TOK_SETUP;
            store_q <= 1'b0;
            pend_q <= HS_ACK;
            hs_valid_q <= 1'b0;
            hs_code_q <= HS_ACK;
            dh_valid_q <= 1'b0;
            dh_data_q <= '0;
            dh_eop_q <= 1'b0;
        end else begin
            hs_valid_q <= 1'b0;
            dh_valid_q <= 1'b0;
            dh_eop_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (link.tok_valid) begin
                        ep_q <= link.tok_ep;
                        kind_q <= link.tok_kind;
                        case (link.tok_kind)
                            TOK_SETUP: begin
                                store_q <= 1'b1;
                                pend_q <= HS_ACK;
                                state_q <= ST_RX;
                            end
                            TOK_OUT: begin
                                state_q <= ST_RX;
                                if (fstall_q[link.tok_ep]) begin
                                    store_q <= 1'b0;
                                    pend_q <= HS_STALL;
                                end else if (rxf_q[link.tok_ep]
                                    || setup_q[link.tok_ep]) begin
                                    store_q <= 1'b0;
                                    pend_q <= HS_NAK;
                                end else begin
                                    store_q <= 1'b1;
                                    pend_q <= HS_ACK;
                                end
                            end
                            default: begin
                                if (fstall_q[link.tok_ep]) begin
                                    hs_valid_q <= 1'b1;
                                    hs_code_q <= HS_STALL;
                                end else if (txrdy_q[link.tok_ep]
                                    [usb_bank_q[link.tok_ep]]) begin
                                    state_q <= ST_TX;
                                end else begin
                                    hs_valid_q <= 1'b1;
                                    hs_code_q <= HS_NAK;
                                end
                            end
                        endcase
                    end
                end
                ST_RX: begin
                    if (link.hd_eop) begin
                        hs_valid_q <= 1'b1;
                        hs_code_q <= pend_q;
                        state_q <= ST_IDLE;
                    end
                end
                ST_TX: begin
                    if (bk_level[usb_b] != '0) begin
                        dh_valid_q <= 1'b1;
                        dh_data_q <= bk_rdata[usb_b];
                    end else begin
                        dh_eop_q <= 1'b1;
                        state_q <= ST_TX_WAIT;
                    end
                end
                ST_TX_WAIT: begin
                    if (link.hack || link.hdrop) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Endpoint flags
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            setup_q <= '0;
            rxf_q <= '0;
            txc_q <= '0;
            stall_sent_q <= '0;
            fstall_q <= '0;
        end else begin
            for (int e = 0; e < NUM_EP; e++) begin
                if (ev_setup[e]) begin
                    setup_q[e] <= 1'b1;
                end else if (csr_wr[e] && wdata_i[CSR_SETUP_BIT]) begin
                    setup_q[e] <= 1'b0;
                end
                if (ev_rx[e]) begin
                    rxf_q[e] <= 1'b1;
                end else if (csr_wr[e] && wdata_i[CSR_RXBK0_BIT]) begin
                    rxf_q[e] <= 1'b0;
                end
                if (ev_ack[e]) begin
                    txc_q[e] <= 1'b1;
                end else if (csr_wr[e] && wdata_i[CSR_TX_COMPLETE_FLAG_BIT]) begin
                    txc_q[e] <= 1'b0;
                end
                if (ev_stall[e]) begin
                    stall_sent_q[e] <= 1'b1;
                end else if (csr_wr[e] && wdata_i[CSR_STALLSENT_BIT]) begin
                    stall_sent_q[e] <= 1'b0;
                end
                if (ev_setup[e]) begin
                    fstall_q[e] <= 1'b0;
                end else if (csr_wr[e]) begin
                    fstall_q[e] <= wdata_i[CSR_FSTALL_BIT];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            txrdy_q <= '0;
            fw_bank_q <= '0;
            usb_bank_q <= '0;
        end else begin
            for (int e = 0; e < NUM_EP; e++) begin
                if (ev_ack[e]) begin
                    txrdy_q[e][usb_bank_q[e]] <= 1'b0;
                    usb_bank_q[e] <= PP_MASK[e] & ~usb_bank_q[e];
                end
                if (csr_wr[e] && wdata_i[CSR_TXRDY_BIT]) begin
                    txrdy_q[e][fw_bank_q[e]] <= 1'b1;
                    fw_bank_q[e] <= PP_MASK[e] & ~fw_bank_q[e];
                end
            end
        end
    end

    // ************************************************************
    // Interrupts and read data
    // ************************************************************
    assign pend = setup_q | rxf_q | txc_q | stall_sent_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            int_en_q <= INT_EN_RST;
            ep_int_o <= '0;
        end else begin
            if (we_i && addr_i == INT_EN_ADDR) begin
                int_en_q <= wdata_i[NUM_EP-1:0];
            end
            ep_int_o <= pend & int_en_q;
        end
    end

    always_comb begin
        rd_mux = '0;
        if (addr_i == INT_EN_ADDR) begin
            rd_mux[NUM_EP-1:0] = int_en_q;
        end else if (addr_i == INT_PEND_ADDR) begin
            rd_mux[NUM_EP-1:0] = pend;
        end else begin
            for (int e = 0; e < NUM_EP; e++) begin
                if (addr_i == CSR_BASE + 8'(e) * EP_STRIDE) begin
                    rd_mux[CSR_TX_COMPLETE_FLAG_BIT] = txc_q[e];
                    rd_mux[CSR_RXBK0_BIT] = rxf_q[e];
                    rd_mux[CSR_SETUP_BIT] = setup_q[e];
                    rd_mux[CSR_STALLSENT_BIT] = stall_sent_q[e];
                    rd_mux[CSR_TXRDY_BIT] = txrdy_q[e][fw_bank_q[e]];
                    rd_mux[CSR_FSTALL_BIT] = fstall_q[e];
                    rd_mux[CSR_PP_BIT] = PP_MASK[e];
                    rd_mux[CSR_CNT_LSB +: CSR_CNT_W] =
                        CSR_CNT_W'(bk_level[2*e]);
                end else if (addr_i == FIFO_BASE + 8'(e) * EP_STRIDE) begin
                    rd_mux[7:0] = bk_rdata[2*e];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= re_i ? rd_mux : '0;
        end
    end
endmodule : usb_endpoint_transaction_handler
`default_nettype wire

/* File: design/usb_host_end.sv */
`default_nettype none
module usb_host_end (
    input wire logic clk_i,
    input wire logic rst_n_i,
    usb_link_if.host link,
    input wire logic cmd_valid_i,
    input wire usb_ep_pkg::tok_kind_t cmd_kind_i,
    input wire logic [usb_ep_pkg::EP_W-1:0] cmd_ep_i,
    input wire logic [usb_ep_pkg::LVL_W-1:0] cmd_len_i,
    input wire logic cmd_drop_i,
    output logic cmd_ready_o,
    output logic byte_req_o,
    input wire logic [7:0] byte_i,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    output logic done_o,
    output usb_ep_pkg::hs_code_t done_hs_o
);
    import usb_ep_pkg::*;

    host_state_t state_q;
    logic [LVL_W-1:0] cnt_q;
    logic drop_q;
    logic tok_valid_q;
    tok_kind_t tok_kind_q;
    logic [EP_W-1:0] tok_ep_q;
    logic hd_valid_q;
    logic [7:0] hd_data_q;
    logic hd_eop_q;
    logic hack_q;
    logic hdrop_q;

    assign link.tok_valid = tok_valid_q;
    assign link.tok_kind = tok_kind_q;
    assign link.tok_ep = tok_ep_q;
    assign link.hd_valid = hd_valid_q;
    assign link.hd_data = hd_data_q;
    assign link.hd_eop = hd_eop_q;
    assign link.hack = hack_q;
    assign link.hdrop = hdrop_q;
    assign cmd_ready_o = (state_q == H_IDLE);
    assign byte_req_o = (state_q == H_SEND) && (cnt_q != '0);

    // ************************************************************
    // Transaction issue
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q <= H_IDLE;
            cnt_q <= '0;
            drop_q <= 1'b0;
            tok_valid_q <= 1'b0;
            tok_kind_q <= TOK_SETUP;
            tok_ep_q <= '0;
            hd_valid_q <= 1'b0;
            hd_data_q <= '0;
            hd_eop_q <= 1'b0;
            hack_q <= 1'b0;
            hdrop_q <= 1'b0;
            rx_valid_o <= 1'b0;
            rx_data_o <= '0;
            done_o <= 1'b0;
            done_hs_o <= HS_ACK;
        end else begin
            tok_valid_q <= 1'b0;
            hd_valid_q <= 1'b0;
            hd_eop_q <= 1'b0;
            hack_q <= 1'b0;
            hdrop_q <= 1'b0;
            rx_valid_o <= 1'b0;
            done_o <= 1'b0;
            case (state_q)
                H_IDLE: begin
                    if (cmd_valid_i) begin
                        tok_valid_q <= 1'b1;
                        tok_kind_q <= cmd_kind_i;
                        tok_ep_q <= cmd_ep_i;
                        cnt_q <= cmd_len_i;
                        drop_q <= cmd_drop_i;
                        state_q <= (cmd_kind_i == TOK_IN) ? H_WAIT : H_SEND;
                    end
                end
                H_SEND: begin
                    if (cnt_q != '0) begin
                        hd_valid_q <= 1'b1;
                        hd_data_q <= byte_i;
                        cnt_q <= cnt_q - LVL_W'(1);
                    end else begin
                        hd_eop_q <= 1'b1;
                        state_q <= H_WAIT;
                    end
                end
                H_WAIT: begin
                    if (link.dh_valid) begin
                        rx_valid_o <= 1'b1;
                        rx_data_o <= link.dh_data;
                    end
                    if (link.hs_valid) begin
                        done_o <= 1'b1;
                        done_hs_o <= link.hs_code;
                        state_q <= H_IDLE;
                    end else if (link.dh_eop) begin
                        hack_q <= !drop_q;
                        hdrop_q <= drop_q;
                        done_o <= 1'b1;
                        done_hs_o <= drop_q ? HS_NAK : HS_ACK;
                        state_q <= H_IDLE;
                    end
                end
                default: begin
                    state_q <= H_IDLE;
                end
            endcase
        end
    end
endmodule : usb_host_end
`default_nettype wire

/* File: tb/usb_endpoint_transaction_handler_test.sv */
`default_nettype none
module usb_endpoint_transaction_handler_test;
    import usb_ep_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, rst_n_i = 0, we_i = 0, re_i = 0, cmd_valid_i = 0;
    logic cmd_drop_i = 0, cmd_ready_o, byte_req_o, rx_valid_o, done_o;
    logic [7:0] addr_i = '0, bidx = '0, rx_data_o, rx;
    logic [31:0] wdata_i = '0, rdata_o, d;
    logic [3:0] ep_int_o;
    logic [1:0] cmd_ep_i = '0;
    logic [6:0] cmd_len_i = '0;
    wire logic [7:0] byte_i = 8'ha0 + bidx;
    tok_kind_t cmd_kind_i = TOK_SETUP;
    hs_code_t done_hs_o;
    int n_mismatch = 0, comparisons = 0;
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i)
        bidx <= (cmd_valid_i && cmd_ready_o) ? 8'h00 : bidx + 8'(byte_req_o);
    usb_link_if link ();
    usb_endpoint_transaction_handler u_usb_endpoint_transaction_handler (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .link(link), .addr_i(addr_i),
        .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
        .ep_int_o(ep_int_o));
    usb_host_end u_usb_host_end (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .link(link), .cmd_valid_i(cmd_valid_i), .cmd_kind_i(cmd_kind_i),
        .cmd_ep_i(cmd_ep_i), .cmd_len_i(cmd_len_i), .cmd_drop_i(cmd_drop_i),
        .cmd_ready_o(cmd_ready_o), .byte_req_o(byte_req_o), .byte_i(byte_i),
        .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o), .done_o(done_o),
        .done_hs_o(done_hs_o));
    usb_link_chk u_usb_link_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .tok_valid(link.tok_valid), .tok_kind(link.tok_kind),
        .hd_eop(link.hd_eop), .hs_valid(link.hs_valid),
        .hs_code(link.hs_code), .dh_valid(link.dh_valid),
        .dh_eop(link.dh_eop));
    task automatic summarize;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        we_i <= 1'b1;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        addr_i <= a;
        re_i <= 1'b1;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1 d = rdata_o;
    endtask : rd
    task automatic pop(input logic [7:0] a, input int n);
        for (int i = 0; i < n; i++) begin
            rd(a);
            chk(32'(d[7:0]), 32'h00a0 + 32'(i));
        end
    endtask : pop
    task automatic cmd(input tok_kind_t k, input logic [1:0] ep,
        input logic [6:0] n, input hs_code_t e);
        @(posedge clk_i);
        chk(32'(cmd_ready_o), 1);
        rx = 8'h00;
        cmd_valid_i <= 1'b1;
        cmd_kind_i <= k;
        cmd_ep_i <= ep;
        cmd_len_i <= n;
        @(posedge clk_i);
        cmd_valid_i <= 1'b0;
        for (int i = 0; i < 99 && done_o !== 1'b1; i++) begin
            @(posedge clk_i);
            #1 if (rx_valid_o === 1'b1) rx = rx_data_o;
        end
        if (done_o !== 1'b1) begin
            $display("wrong value at %0t: no end of transaction", $time);
            n_mismatch++;
            summarize();
        end
        chk(32'(done_hs_o), 32'(e));
    endtask : cmd
    task automatic t_ctrl;
        cmd(TOK_SETUP, 2'h0, 7'h08, HS_ACK);
        rd(CSR_BASE);
        chk(32'(d[CSR_SETUP_BIT]), 1);
        rd(INT_PEND_ADDR);
        chk(32'(d[0]), 1);
        chk(32'(ep_int_o), 0);
        wr(INT_EN_ADDR, 32'h0000_0001);
        @(posedge clk_i);
        #1 chk(32'(ep_int_o), 1);
        cmd(TOK_OUT, 2'h0, 7'h02, HS_NAK);
        pop(FIFO_BASE, 8);
        wr(CSR_BASE, 32'h0000_0004);
        cmd(TOK_OUT, 2'h0, 7'h02, HS_ACK);
        rd(CSR_BASE);
        chk(32'(d[CSR_RXBK0_BIT]), 1);
        chk(32'(d[26:16]), 2);
        chk(32'(ep_int_o), 1);
        cmd(TOK_OUT, 2'h0, 7'h02, HS_NAK);
        pop(FIFO_BASE, 2);
        wr(CSR_BASE, 32'h0000_0002);
        cmd(TOK_OUT, 2'h0, 7'h00, HS_ACK);
        cmd(TOK_SETUP, 2'h0, 7'h0a, HS_ACK);
        rd(CSR_BASE);
        chk(32'(d[26:16]), 8);
        chk(32'(d[CSR_PP_BIT]), 0);
    endtask : t_ctrl
    task automatic t_in;
        cmd(TOK_IN, 2'h3, 7'h00, HS_NAK);
        wr(FIFO_BASE + 8'h18, 32'h0000_005a);
        wr(CSR_BASE + 8'h18, 32'h0000_0010);
        cmd(TOK_IN, 2'h3, 7'h00, HS_ACK);
        chk(32'(rx), 32'h0000_005a);
        rd(CSR_BASE + 8'h18);
        chk(32'(d[CSR_TX_COMPLETE_FLAG_BIT]), 1);
        chk(32'(d[CSR_TXRDY_BIT]), 0);
        wr(CSR_BASE + 8'h18, 32'h0000_0021);
        cmd(TOK_OUT, 2'h3, 7'h01, HS_STALL);
        cmd(TOK_SETUP, 2'h3, 7'h08, HS_ACK);
        rd(CSR_BASE + 8'h18);
        chk(32'(d[CSR_FSTALL_BIT]), 0);
        chk(32'(d[CSR_STALLSENT_BIT]), 1);
    endtask : t_in
    task automatic t_pp;
        rd(CSR_BASE + 8'h08);
        chk(32'(d[CSR_TXRDY_BIT]), 0);
        chk(32'(d[CSR_PP_BIT]), 1);
        wr(FIFO_BASE + 8'h08, 32'h0000_0011);
        wr(CSR_BASE + 8'h08, 32'h0000_0010);
        wr(FIFO_BASE + 8'h08, 32'h0000_0022);
        cmd(TOK_IN, 2'h1, 7'h00, HS_ACK);
        chk(32'(rx), 32'h0000_0011);
        wr(CSR_BASE + 8'h08, 32'h0000_0011);
        @(posedge clk_i) cmd_drop_i <= 1'b1;
        cmd(TOK_IN, 2'h1, 7'h00, HS_NAK);
        chk(32'(rx), 32'h0000_0022);
        @(posedge clk_i) cmd_drop_i <= 1'b0;
        cmd(TOK_IN, 2'h1, 7'h00, HS_ACK);
        chk(32'(rx), 32'h0000_0022);
        rd(CSR_BASE + 8'h08);
        chk(32'(d[CSR_TX_COMPLETE_FLAG_BIT]), 1);
        chk(32'(d[CSR_TXRDY_BIT]), 0);
    endtask : t_pp
    initial begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_ctrl();
        t_in();
        t_pp();
        summarize();
    end
endmodule : usb_endpoint_transaction_handler_test
`default_nettype wire

/* File: tb/usb_link_chk.sv */
`default_nettype none
module usb_link_chk (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tok_valid,
    input wire usb_ep_pkg::tok_kind_t tok_kind,
    input wire logic hd_eop,
    input wire logic hs_valid,
    input wire usb_ep_pkg::hs_code_t hs_code,
    input wire logic dh_valid,
    input wire logic dh_eop
);
    import usb_ep_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic setup_q;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    always_ff @(posedge clk_i) begin
        if (!rst_n_i)
            setup_q <= 1'b0;
        else if (tok_valid)
            setup_q <= (tok_kind == TOK_SETUP);
    end
    AST_SETUP_ACK: assert property (hs_valid && setup_q |->
        hs_code == HS_ACK) else $error("setup not acknowledged");
    AST_EOP_HS: assert property (hd_eop |=> hs_valid)
        else $error("no handshake after host packet");
    AST_IN_ANSWER: assert property (tok_valid && tok_kind == TOK_IN |->
        ##1 (hs_valid && hs_code != HS_ACK) or ##2 (dh_valid || dh_eop))
        else $error("in token not answered");
    AST_HS_ONE: assert property (hs_valid |=> !hs_valid)
        else $error("handshake longer than one cycle");
    AST_HS_CAUSE: assert property (hs_valid |->
        $past(hd_eop) || $past(tok_valid)) else $error("stray handshake");
    AST_HS_LEGAL: assert property (hs_valid |->
        hs_code inside {HS_ACK, HS_NAK, HS_STALL}) else $error("bad code");
    AST_NO_OVERLAP: assert property (dh_valid |-> !hs_valid)
        else $error("data and handshake together");
    AST_IN_NOT_ACK: assert property (hs_valid && !$past(hd_eop) |->
        hs_code != HS_ACK) else $error("in token acknowledged");
endmodule : usb_link_chk
`default_nettype wire
